// ---- design/icoc_pkg.sv ----
// Package for the capture/compare block: register map, field layout and type definitions.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package icoc_pkg;

  // Register byte offsets.
  localparam logic [7:0] ICOC_CAP_CTRL_OFF = 8'h00;
  localparam logic [7:0] ICOC_CAP_BUF_OFF = 8'h04;
  localparam logic [7:0] ICOC_CMP_CTRL_OFF = 8'h08;
  localparam logic [7:0] ICOC_CMP_PRI_OFF = 8'h0C;
  localparam logic [7:0] ICOC_CMP_SEC_OFF = 8'h10;
  localparam logic [7:0] ICOC_STAT_OFF = 8'h14;

  // Capture control fields.
  localparam int ICOC_CAP_IDLE_BIT = 13;
  localparam int ICOC_CAP_TSEL_BIT = 7;
  localparam int ICOC_CAP_CPI_LSB = 5;
  localparam int ICOC_CAP_OVF_BIT = 4;
  localparam int ICOC_CAP_BNE_BIT = 3;
  localparam int ICOC_CAP_MODE_LSB = 0;

  // Compare control fields.
  localparam int ICOC_CMP_IDLE_BIT = 13;
  localparam int ICOC_CMP_FLT_BIT = 4;
  localparam int ICOC_CMP_TSEL_BIT = 3;
  localparam int ICOC_CMP_MODE_LSB = 0;

  // Reset values.
  localparam logic [15:0] ICOC_CTRL_RST = 16'h0000;
  localparam logic [15:0] ICOC_VAL_RST = 16'h0000;

  // Capture buffer depth and prescale counts.
  localparam int ICOC_FIFO_DEPTH = 4;
  localparam logic [3:0] ICOC_PRE4_LAST = 4'h3;
  localparam logic [3:0] ICOC_PRE16_LAST = 4'hF;

  // Capture modes.
  localparam logic [2:0] ICOC_CM_OFF = 3'h0;
  localparam logic [2:0] ICOC_CM_EDGE = 3'h1;
  localparam logic [2:0] ICOC_CM_FALL = 3'h2;
  localparam logic [2:0] ICOC_CM_RISE = 3'h3;
  localparam logic [2:0] ICOC_CM_RISE4 = 3'h4;
  localparam logic [2:0] ICOC_CM_RISE16 = 3'h5;
  localparam logic [2:0] ICOC_CM_WAKE = 3'h7;

  // Compare modes.
  typedef enum logic [2:0] {
    ICOC_OM_OFF = 3'h0,
    ICOC_OM_SET = 3'h1,
    ICOC_OM_CLR = 3'h2,
    ICOC_OM_TOG = 3'h3,
    ICOC_OM_ONE = 3'h4,
    ICOC_OM_CONT = 3'h5,
    ICOC_OM_PWM = 3'h6,
    ICOC_OM_PWMF = 3'h7
  } icoc_omode_t;

  // Pulse state machine for the delayed one-shot.
  typedef enum logic [2:0] {
    ICOC_PS_WAIT = 3'b001,
    ICOC_PS_HIGH = 3'b010,
    ICOC_PS_DONE = 3'b100
  } icoc_pstate_t;

  // Timer inputs travel together.
  typedef struct packed {
    logic [15:0] second;
    logic [15:0] third;
  } icoc_timers_t;

endpackage : icoc_pkg

// ---- design/icoc_top.sv ----
// Input capture channel and output compare channel with an APB register file.
// Assumes the two 16-bit timers, idle indication and enable come from logic on pclk;
// capture_pin and fault_input are asynchronous pins and are synchronised here.
//
// Summary of operation
// - Capture idle-stop bit 13 set halts the capture channel during CPU Idle.
// - Capture timer-select bit 7: 1 latches second timer, 0 latches third timer.
// - Captures-per-interrupt 00..11 interrupts after every 1st..4th capture.
// - Capture overflow bit 4 is read-only, hardware sets and clears it.
// - Buffer-not-empty bit 3 reads 1 while any captured value is unread.
// - Capture mode picks edge: any, falling, rising, 4th rising, 16th rising.
// - Capture mode 111 makes the pin a rising-edge wake interrupt in sleep/idle only.
// - Capture modes 000 and 110 leave the capture channel disabled.
// - Every-edge mode interrupts on each capture, ignoring captures-per-interrupt.
// - Compare timer-select bit 3: 1 uses third timer, 0 uses second timer.
// - Compare idle-stop bit 13 set halts the compare channel during CPU Idle, except the mode 111 fault shutdown.
// - Compare mode 000 disables compare; pin follows the port latch, no interrupt.
// - Mode 001 starts low, goes high on match, interrupts on that rise.
// - Mode 010 starts high, goes low on match, interrupts on that fall.
// - Mode 011 keeps level, toggles on each match, interrupts on both edges.
// - Mode 100 starts low, makes one pulse, interrupts on its falling edge.
// - Mode 101 starts low, makes continuous pulses, interrupts on each fall.
// - Mode 110 is PWM, initial level from primary value nonzero, no interrupt.
// - Mode 111 is PWM with fault input; interrupt on fault falling edge.
// - Fault status bit 4 sets on fault in mode 111, cleared by hardware only.
// - Compare selected timer with one or two values and change pin on match.
// - Each capture event latches the full 16-bit selected timer count.
// - Captures sit in a four-entry FIFO, read by software in arrival order.
//
// Decided for this implementation: the register offsets and register access over APB.
module icoc_top
  import icoc_pkg::*;
#(
  parameter int DEPTH = ICOC_FIFO_DEPTH
) (
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System.
  input wire logic clk_en,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire icoc_timers_t timers,
  input wire logic port_latch,
  // Pins.
  input wire logic capture_pin,
  input wire logic fault_input,
  output logic compare_output_pin,
  // Event pulses.
  output logic capture_irq,
  output logic compare_irq
);

  localparam int PW = $clog2(DEPTH);

  // Control and data registers.
  logic cap_idle_reg, cap_tsel_reg;
  logic [1:0] cap_cpi_reg;
  logic [2:0] cap_mode_reg;
  logic cap_ovf_reg;
  logic cmp_idle_reg, cmp_tsel_reg, cmp_flt_reg;
  logic [2:0] cmp_mode_reg;
  logic [15:0] pri_reg, sec_reg;
  logic [15:0] fifo_mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [PW:0] count_reg;
  logic [3:0] pre_reg;
  logic [1:0] cpi_cnt_reg;
  logic [1:0] cap_sync_reg, flt_sync_reg;
  logic cap_prev_reg, flt_prev_reg;
  logic out_reg;
  icoc_pstate_t pst_reg;

  // APB decode; the slave always answers in the access cycle.
  logic wr_en, rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Synchronisers: the first stage feeds only the second.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_sync_reg <= 2'h0;
      flt_sync_reg <= 2'h3;
      cap_prev_reg <= 1'b0;
      flt_prev_reg <= 1'b1;
    end else if (clk_en) begin
      cap_sync_reg <= {cap_sync_reg[0], capture_pin};
      flt_sync_reg <= {flt_sync_reg[0], fault_input};
      cap_prev_reg <= cap_sync_reg[1];
      flt_prev_reg <= flt_sync_reg[1];
    end
  end

  logic rise, fall, flt_fall;
  assign rise = cap_sync_reg[1] && !cap_prev_reg;
  assign fall = !cap_sync_reg[1] && cap_prev_reg;
  assign flt_fall = !flt_sync_reg[1] && flt_prev_reg;

  // Capture run condition and trigger selection.
  logic cap_run, cap_evt, pre_hit;
  assign cap_run = !(cap_idle_reg && cpu_idle);
  assign pre_hit = (cap_mode_reg == ICOC_CM_RISE4) ? (pre_reg == ICOC_PRE4_LAST)
                                                   : (pre_reg == ICOC_PRE16_LAST);
  always_comb begin
    cap_evt = 1'b0;
    if (cap_run) begin
      case (cap_mode_reg)
        ICOC_CM_EDGE: cap_evt = rise || fall;
        ICOC_CM_FALL: cap_evt = fall;
        ICOC_CM_RISE: cap_evt = rise;
        ICOC_CM_RISE4, ICOC_CM_RISE16: cap_evt = rise && pre_hit;
        default: cap_evt = 1'b0;
      endcase
    end
  end

  // Edge prescaler for the every-4th and every-16th rising modes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 4'h0;
    end else if (clk_en) begin
      if (cap_mode_reg != ICOC_CM_RISE4 && cap_mode_reg != ICOC_CM_RISE16) begin
        pre_reg <= 4'h0;
      end else if (cap_run && rise) begin
        pre_reg <= pre_hit ? 4'h0 : pre_reg + 4'h1;
      end
    end
  end

  logic [15:0] cap_val;
  assign cap_val = cap_tsel_reg ? timers.second : timers.third;

  // FIFO bookkeeping; a read of the buffer register pops one entry.
  logic push, pop, full;
  assign full = (count_reg == (PW+1)'(DEPTH));
  assign push = cap_evt && !full;
  assign pop = rd_en && hit(paddr, ICOC_CAP_BUF_OFF) && (count_reg != '0);

  always_ff @(posedge pclk) begin
    if (clk_en && push) begin
      fifo_mem[wr_ptr_reg] <= cap_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (clk_en) begin
      if (cap_mode_reg == ICOC_CM_OFF) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        count_reg <= '0;
      end else begin
        if (push) wr_ptr_reg <= wr_ptr_reg + PW'(1);
        if (pop) rd_ptr_reg <= rd_ptr_reg + PW'(1);
        count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
      end
    end
  end

  // Overflow: set by a capture into a full buffer, cleared by hardware once the buffer
  // drains or the channel is turned off. Set wins over a concurrent clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_ovf_reg <= 1'b0;
    end else if (clk_en) begin
      if (cap_evt && full) begin
        cap_ovf_reg <= 1'b1;
      end else if (cap_mode_reg == ICOC_CM_OFF || count_reg == '0) begin
        cap_ovf_reg <= 1'b0;
      end
    end
  end

  // Capture interrupt counting and wake-up interrupt.
  logic cap_irq_next;
  always_comb begin
    cap_irq_next = 1'b0;
    if (cap_mode_reg == ICOC_CM_WAKE) begin
      cap_irq_next = rise && (cpu_sleep || cpu_idle);
    end else if (push) begin
      cap_irq_next = (cap_mode_reg == ICOC_CM_EDGE)
                     || (cpi_cnt_reg == cap_cpi_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpi_cnt_reg <= 2'h0;
      capture_irq <= 1'b0;
    end else if (clk_en) begin
      capture_irq <= cap_irq_next;
      if (cap_mode_reg == ICOC_CM_OFF) begin
        cpi_cnt_reg <= 2'h0;
      end else if (push) begin
        cpi_cnt_reg <= (cpi_cnt_reg == cap_cpi_reg) ? 2'h0 : cpi_cnt_reg + 2'h1;
      end
    end
  end

  // Compare engine.
  logic [15:0] cmp_tmr;
  logic cmp_run, pri_hit, sec_hit, mode_wr;
  icoc_omode_t om;
  assign om = icoc_omode_t'(cmp_mode_reg);
  assign cmp_tmr = cmp_tsel_reg ? timers.third : timers.second;
  assign cmp_run = !(cmp_idle_reg && cpu_idle);
  assign pri_hit = cmp_run && (cmp_tmr == pri_reg);
  assign sec_hit = cmp_run && (cmp_tmr == sec_reg);
  assign mode_wr = wr_en && hit(paddr, ICOC_CMP_CTRL_OFF)
                   && (pwdata[2:0] != cmp_mode_reg);

  // Output level, pulse state and compare interrupt. A mode write sets the initial level.
  // The mode should only change with the time base stopped, since a match in the write
  // cycle is dropped in favour of the initial level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= 1'b0;
      pst_reg <= ICOC_PS_WAIT;
      compare_irq <= 1'b0;
    end else if (clk_en) begin
      compare_irq <= 1'b0;
      if (mode_wr) begin
        pst_reg <= ICOC_PS_WAIT;
        case (icoc_omode_t'(pwdata[2:0]))
          ICOC_OM_SET, ICOC_OM_ONE, ICOC_OM_CONT: out_reg <= 1'b0;
          ICOC_OM_CLR: out_reg <= 1'b1;
          ICOC_OM_PWM, ICOC_OM_PWMF: out_reg <= (pri_reg != 16'h0000);
          default: out_reg <= out_reg;
        endcase
      end else begin
        case (om)
          ICOC_OM_SET: if (pri_hit && !out_reg) begin
            out_reg <= 1'b1;
            compare_irq <= 1'b1;
          end
          ICOC_OM_CLR: if (pri_hit && out_reg) begin
            out_reg <= 1'b0;
            compare_irq <= 1'b1;
          end
          ICOC_OM_TOG: if (pri_hit) begin
            out_reg <= !out_reg;
            compare_irq <= 1'b1;
          end
          ICOC_OM_ONE: begin
            case (pst_reg)
              ICOC_PS_WAIT: if (pri_hit) begin
                out_reg <= 1'b1;
                pst_reg <= ICOC_PS_HIGH;
              end
              ICOC_PS_HIGH: if (sec_hit) begin
                out_reg <= 1'b0;
                compare_irq <= 1'b1;
                pst_reg <= ICOC_PS_DONE;
              end
              default: pst_reg <= ICOC_PS_DONE;
            endcase
          end
          ICOC_OM_CONT: begin
            if (pri_hit) begin
              out_reg <= 1'b1;
            end else if (sec_hit && out_reg) begin
              out_reg <= 1'b0;
              compare_irq <= 1'b1;
            end
          end
          ICOC_OM_PWM, ICOC_OM_PWMF: begin
            if (om == ICOC_OM_PWMF && (cmp_flt_reg || !flt_sync_reg[1])) begin
              out_reg <= 1'b0;
              compare_irq <= flt_fall && !cmp_flt_reg;
            end else if (cmp_run && cmp_tmr == 16'h0000) begin
              out_reg <= (pri_reg != 16'h0000);
            end else if (pri_hit) begin
              out_reg <= 1'b0;
            end
          end
          default: out_reg <= out_reg;
        endcase
      end
    end
  end

  // Fault status: latched on fault in mode 111; cleared by hardware when the mode
  // leaves 111 or the fault input returns high. Set wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_flt_reg <= 1'b0;
    end else if (clk_en) begin
      if (om == ICOC_OM_PWMF && flt_fall) begin
        cmp_flt_reg <= 1'b1;
      end else if (om != ICOC_OM_PWMF || flt_sync_reg[1]) begin
        cmp_flt_reg <= 1'b0;
      end
    end
  end

  // Pin driver: port latch when disabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_output_pin <= 1'b0;
    end else if (clk_en) begin
      compare_output_pin <= (om == ICOC_OM_OFF) ? port_latch : out_reg;
    end
  end

  // Register writes; status bits are not writable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cap_idle_reg, cap_tsel_reg, cap_cpi_reg, cap_mode_reg} <= 7'h00;
      {cmp_idle_reg, cmp_tsel_reg, cmp_mode_reg} <= 5'h00;
      pri_reg <= ICOC_VAL_RST;
      sec_reg <= ICOC_VAL_RST;
    end else if (clk_en && wr_en) begin
      if (hit(paddr, ICOC_CAP_CTRL_OFF)) begin
        cap_idle_reg <= pwdata[ICOC_CAP_IDLE_BIT];
        cap_tsel_reg <= pwdata[ICOC_CAP_TSEL_BIT];
        cap_cpi_reg <= pwdata[ICOC_CAP_CPI_LSB +: 2];
        cap_mode_reg <= pwdata[ICOC_CAP_MODE_LSB +: 3];
      end
      if (hit(paddr, ICOC_CMP_CTRL_OFF)) begin
        cmp_idle_reg <= pwdata[ICOC_CMP_IDLE_BIT];
        cmp_tsel_reg <= pwdata[ICOC_CMP_TSEL_BIT];
        cmp_mode_reg <= pwdata[ICOC_CMP_MODE_LSB +: 3];
      end
      if (hit(paddr, ICOC_CMP_PRI_OFF)) pri_reg <= pwdata[15:0];
      if (hit(paddr, ICOC_CMP_SEC_OFF)) sec_reg <= pwdata[15:0];
    end
  end

  // Read mux, registered into prdata in the access cycle.
  logic [15:0] rmux;
  logic bad;
  always_comb begin
    rmux = ICOC_CTRL_RST;
    bad = 1'b0;
    case (paddr)
      ICOC_CAP_CTRL_OFF: begin
        rmux[ICOC_CAP_IDLE_BIT] = cap_idle_reg;
        rmux[ICOC_CAP_TSEL_BIT] = cap_tsel_reg;
        rmux[ICOC_CAP_CPI_LSB +: 2] = cap_cpi_reg;
        rmux[ICOC_CAP_OVF_BIT] = cap_ovf_reg;
        rmux[ICOC_CAP_BNE_BIT] = (count_reg != '0);
        rmux[ICOC_CAP_MODE_LSB +: 3] = cap_mode_reg;
      end
      ICOC_CAP_BUF_OFF: rmux = (count_reg != '0) ? fifo_mem[rd_ptr_reg] : 16'h0000;
      ICOC_CMP_CTRL_OFF: begin
        rmux[ICOC_CMP_IDLE_BIT] = cmp_idle_reg;
        rmux[ICOC_CMP_FLT_BIT] = cmp_flt_reg;
        rmux[ICOC_CMP_TSEL_BIT] = cmp_tsel_reg;
        rmux[ICOC_CMP_MODE_LSB +: 3] = cmp_mode_reg;
      end
      ICOC_CMP_PRI_OFF: rmux = pri_reg;
      ICOC_CMP_SEC_OFF: rmux = sec_reg;
      ICOC_STAT_OFF: rmux = {15'h0000, out_reg};
      default: bad = 1'b1;
    endcase
  end

  // APB answer: pready pulses in the access cycle's following edge window.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && bad;
      if (psel && !penable && !pwrite) prdata <= {16'h0000, rmux};
    end
  end

endmodule : icoc_top

// ---- tb/icoc_assertions.sv ----
// Checker for the capture/compare block, on top module ports only.
// Assumes control words change only by APB writes with clk_en high.
module icoc_chk
  import icoc_pkg::*;
(
  // APB side.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // System and pins.
  input wire logic clk_en,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic port_latch,
  input wire logic compare_output_pin,
  input wire logic capture_irq,
  input wire logic compare_irq
);
  logic wr_go;
  logic [15:0] cap_reg;
  logic [15:0] cmp_reg;
  logic [3:0] cap_age;
  logic [3:0] cmp_age;
  logic [3:0] idle_age;
  logic [3:0] wake_age;

  function automatic logic [3:0] age_step(input logic [3:0] a, input logic clr);
    return clr ? 4'h0 : ((a == 4'hF) ? a : a + 4'h1);
  endfunction : age_step

  assign wr_go = psel && penable && pwrite && pready && clk_en;

  // Shadows and ages; a write restarts the age, as synchroniser events are stale.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_reg <= 16'h0000;
      cmp_reg <= 16'h0000;
      cap_age <= 4'h0;
      cmp_age <= 4'h0;
      idle_age <= 4'h0;
      wake_age <= 4'h0;
    end else begin
      if (wr_go && paddr == ICOC_CAP_CTRL_OFF) cap_reg <= pwdata[15:0];
      if (wr_go && paddr == ICOC_CMP_CTRL_OFF) cmp_reg <= pwdata[15:0];
      cap_age <= age_step(cap_age, wr_go && paddr == ICOC_CAP_CTRL_OFF);
      cmp_age <= age_step(cmp_age, wr_go && paddr == ICOC_CMP_CTRL_OFF);
      idle_age <= age_step(idle_age, !cpu_idle);
      wake_age <= age_step(wake_age, cpu_idle || cpu_sleep);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_evt(logic [2:0] m);
    compare_irq && cmp_reg[2:0] == m && cmp_age == 4'hF;
  endsequence

  chk_zero_wait: assert property (psel && !penable |=> pready && penable)
    else $error("late answer");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready held");
  chk_unmapped_err: assert property (psel && !penable
    && (paddr > ICOC_STAT_OFF || paddr[1:0] != 2'h0) |=> pslverr)
    else $error("no refusal");
  chk_off_quiet: assert property (cmp_reg[2:0] == ICOC_OM_OFF && cmp_age == 4'hF
    |-> !compare_irq) else $error("irq while off");
  chk_latch_follow: assert property (cmp_reg[2:0] == ICOC_OM_OFF && cmp_age == 4'hF
    && $changed(port_latch) |-> ##[1:3] compare_output_pin == port_latch)
    else $error("pin ignores latch");
  chk_pwm_quiet: assert property (cmp_reg[2:0] == ICOC_OM_PWM && cmp_age == 4'hF
    |-> !compare_irq) else $error("irq in pwm");
  chk_set_rise: assert property (s_evt(ICOC_OM_SET) |=> $rose(compare_output_pin))
    else $error("no rise");
  chk_clr_fall: assert property (s_evt(ICOC_OM_CLR) |=> $fell(compare_output_pin))
    else $error("no fall");
  chk_tog_flip: assert property (s_evt(ICOC_OM_TOG)
    |=> compare_output_pin != $past(compare_output_pin))
    else $error("no toggle");
  chk_pulse_fall: assert property (compare_irq && cmp_age == 4'hF
    && cmp_reg[2:0] inside {ICOC_OM_ONE, ICOC_OM_CONT} |=> $fell(compare_output_pin))
    else $error("pulse irq without fall");
  chk_cap_off: assert property (cap_age == 4'hF && cap_reg[2:0] inside {3'h0, 3'h6}
    |-> !capture_irq) else $error("capture while off");
  chk_wake_only: assert property (cap_reg[2:0] == ICOC_CM_WAKE && cap_age == 4'hF
    && wake_age == 4'hF |-> !capture_irq) else $error("wake irq while awake");
  chk_cap_halt: assert property (cap_reg[13] && cap_age == 4'hF && idle_age == 4'hF
    && cap_reg[2:0] != ICOC_CM_WAKE |-> !capture_irq) else $error("capture in idle");
  chk_cmp_halt: assert property (cmp_reg[13] && cmp_age == 4'hF && idle_age == 4'hF
    && cmp_reg[2:0] != ICOC_OM_OFF |=> !compare_irq && $stable(compare_output_pin))
    else $error("compare in idle");
endmodule : icoc_chk

bind icoc_top icoc_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .clk_en(clk_en), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .port_latch(port_latch),
  .compare_output_pin(compare_output_pin), .capture_irq(capture_irq),
  .compare_irq(compare_irq));

// ---- tb/icoc_pins.sv ----
// Pin model: capture pulse source, fault switch and a load.
// Assumes pclk as time reference; the fault line idles high by pull-up.
module icoc_pins (
  // Reference clock.
  input wire logic pclk,
  // Load side.
  input wire logic compare_output_pin,
  // Sources.
  output logic capture_pin,
  output logic fault_input
);
  timeunit 1ns;
  timeprecision 1ps;
  int rises = 0;
  logic last_out = 1'b0;

  initial begin
    capture_pin = 1'b0;
    fault_input = 1'b1;
  end

  // Four-cycle pulses clear the two-flop synchroniser.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      capture_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      capture_pin <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask : pulses

  task automatic set_fault(input logic v);
    @(posedge pclk);
    fault_input <= v;
  endtask : set_fault

  // The load counts rising edges of the compare output.
  always @(posedge pclk) begin
    if (compare_output_pin === 1'b1 && last_out === 1'b0) rises++;
    last_out <= compare_output_pin;
  end
endmodule : icoc_pins

// ---- tb/input_capture_output_compare_tb_top.sv ----
// Self-checking bench for the capture/compare block, driven over APB.
// Assumes the pin model and the bound checker are compiled alongside.
module input_capture_output_compare_tb_top
  import icoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, capture_pin, fault_input, compare_output_pin;
  logic capture_irq, compare_irq, pin0, cpu_idle = 1'b0, cpu_sleep = 1'b0;
  logic port_latch = 1'b0, tmr_run = 1'b0, tmr_third = 1'b0, clk_en = 1'b1;
  icoc_timers_t timers = '0;
  int bad_count = 0, n_compared = 0, cap_n = 0, cmp_n = 0, r0;
  // Per mode: code, initial level, final level, interrupts, rising edges.
  int cm[8][5] = '{'{1,0,1,1,1}, '{2,1,0,1,0}, '{3,0,0,2,1}, '{4,0,0,1,1},
    '{5,0,0,2,2}, '{6,1,1,0,2}, '{7,1,1,0,2}, '{0,1,1,0,0}};

  always #20 pclk = ~pclk;

  icoc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_en(clk_en), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
    .timers(timers), .port_latch(port_latch), .capture_pin(capture_pin),
    .fault_input(fault_input), .compare_output_pin(compare_output_pin),
    .capture_irq(capture_irq), .compare_irq(compare_irq));
  icoc_pins pins_u (.pclk(pclk), .compare_output_pin(compare_output_pin),
    .capture_pin(capture_pin), .fault_input(fault_input));

  // The timer wraps at 64 so pulse trains repeat in a short run.
  always @(posedge pclk) begin
    if (tmr_run && tmr_third) timers.third <= (timers.third + 16'h0001) & 16'h003F;
    if (tmr_run && !tmr_third) timers.second <= (timers.second + 16'h0001) & 16'h003F;
    cap_n += int'(capture_irq === 1'b1);
    cmp_n += int'(compare_irq === 1'b1);
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rdc

  task automatic cap_go(input logic [15:0] ctrl, input int n);
    apb(1'b1, ICOC_CAP_CTRL_OFF, 32'h0);
    cap_n = 0;
    apb(1'b1, ICOC_CAP_CTRL_OFF, {16'h0000, ctrl});
    pins_u.pulses(n);
    repeat (6) @(posedge pclk);
  endtask : cap_go

  // The time base is stopped and rewound before every control write.
  task automatic cmp_case(input logic [15:0] ctrl, input logic th);
    tmr_run <= 1'b0;
    tmr_third <= th;
    timers <= th ? {16'h7777, 16'h0000} : {16'h0000, 16'h7777};
    apb(1'b1, ICOC_CMP_CTRL_OFF, {16'h0000, ctrl});
    repeat (4) @(posedge pclk);
    pin0 = compare_output_pin;
    cmp_n = 0;
    r0 = pins_u.rises;
    tmr_run <= 1'b1;
    repeat (128) @(posedge pclk);
    tmr_run <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : cmp_case

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // Cuts a hang far beyond the few thousand cycles expected.
  initial begin
    #800000;
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc("cap ctrl reset", ICOC_CAP_CTRL_OFF, 32'h0);
    rdc("cmp ctrl reset", ICOC_CMP_CTRL_OFF, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    apb(1'b1, ICOC_CMP_PRI_OFF, 32'hFFFF0010);
    rdc("primary", ICOC_CMP_PRI_OFF, 32'h10);
    apb(1'b1, ICOC_CMP_SEC_OFF, 32'h20);
    timers <= {16'hA5C3, 16'h3C5A};
    apb(1'b1, ICOC_CAP_CTRL_OFF, 32'h83);
    pins_u.pulses(1);
    rdc("not empty", ICOC_CAP_CTRL_OFF, 32'h8B);
    rdc("second capture", ICOC_CAP_BUF_OFF, 32'hA5C3);
    rdc("empty", ICOC_CAP_CTRL_OFF, 32'h83);
    apb(1'b1, ICOC_CAP_CTRL_OFF, 32'h03);
    pins_u.pulses(1);
    rdc("third capture", ICOC_CAP_BUF_OFF, 32'h3C5A);
    apb(1'b1, ICOC_CAP_CTRL_OFF, 32'h83);
    for (int k = 0; k < 5; k++) begin
      timers.second <= 16'(16'h1111 * (k + 1));
      pins_u.pulses(1);
    end
    apb(1'b1, ICOC_CAP_CTRL_OFF, 32'h83);
    rdc("overflow kept", ICOC_CAP_CTRL_OFF, 32'h9B);
    for (int k = 0; k < 4; k++) rdc("fifo order", ICOC_CAP_BUF_OFF, 16'(16'h1111 * (k + 1)));
    rdc("overflow cleared", ICOC_CAP_CTRL_OFF, 32'h83);
    rdc("empty read", ICOC_CAP_BUF_OFF, 32'h0);
    // A pin pulse while the clock enable is low must leave no capture behind.
    clk_en <= 1'b0;
    pins_u.pulses(1);
    clk_en <= 1'b1;
    rdc("frozen", ICOC_CAP_CTRL_OFF, 32'h83);
    foreach (cm[i]) begin
      cap_go({13'h0000, 3'(cm[i][0])}, (i == 3) ? 8 : (i == 4) ? 16 : (i == 0) ? 2 : 3);
      check("capture count", cap_n, (i == 0) ? 4 : (i < 3) ? 3 : (i == 3) ? 2 : (i == 4));
    end
    for (int c = 0; c < 4; c++) begin
      cap_go({9'h000, 2'(c), 5'h03}, 4);
      check("captures per irq", cap_n, (c == 0) ? 4 : (c == 1) ? 2 : 1);
    end
    cap_go(16'h0061, 2);
    check("every edge irq", cap_n, 4);
    cpu_sleep <= 1'b1;
    cap_go(16'h0007, 2);
    check("wake irq", cap_n, 2);
    rdc("wake no capture", ICOC_CAP_CTRL_OFF, 32'h07);
    cpu_sleep <= 1'b0;
    cpu_idle <= 1'b1;
    cap_go(16'h2003, 2);
    check("capture idle halt", cap_n, 0);
    cap_go(16'h0003, 2);
    check("capture idle run", cap_n, 2);
    cpu_idle <= 1'b0;
    port_latch <= 1'b1;
    foreach (cm[i]) begin
      cmp_case({13'h0000, 3'(cm[i][0])}, 1'b0);
      check("cmp initial", {31'h0, pin0}, cm[i][1]);
      check("cmp final", {31'h0, compare_output_pin}, cm[i][2]);
      check("cmp irqs", cmp_n, cm[i][3]);
      check("cmp rises", pins_u.rises - r0, cm[i][4]);
    end
    cmp_case(16'h0001, 1'b1);
    check("other timer", cmp_n, 0);
    cmp_case(16'h0009, 1'b1);
    check("third timer match", cmp_n, 1);
    cpu_idle <= 1'b1;
    cmp_case(16'h2003, 1'b0);
    check("compare idle halt", cmp_n, 0);
    cpu_idle <= 1'b0;
    apb(1'b1, ICOC_CMP_PRI_OFF, 32'h0);
    cmp_case(16'h0006, 1'b0);
    check("pwm zero level", {31'h0, pin0}, 32'h0);
    apb(1'b1, ICOC_CMP_PRI_OFF, 32'h10);
    cmp_case(16'h0007, 1'b0);
    pins_u.set_fault(1'b0);
    repeat (6) @(posedge pclk);
    check("fault irq", cmp_n, 1);
    check("fault low", {31'h0, compare_output_pin}, 32'h0);
    rdc("fault status", ICOC_CMP_CTRL_OFF, 32'h17);
    pins_u.set_fault(1'b1);
    repeat (6) @(posedge pclk);
    rdc("fault cleared", ICOC_CMP_CTRL_OFF, 32'h07);
    stop_test();
  end
endmodule : input_capture_output_compare_tb_top
